/* common/scp_map.svh */
// Register offsets, field positions, reset values and frame counts of the serial port
`ifndef SCP_MAP_SVH
`define SCP_MAP_SVH

// ************************************************************
// Register offsets (13-bit register address space)
// ************************************************************
`define SCP_ADDR_CONFIG 13'h0000
`define SCP_ADDR_READBACK 13'h0004
`define SCP_ADDR_PHASE_DET 13'h0010
`define SCP_ADDR_TOP 13'h0232

// ************************************************************
// Reset values
// ************************************************************
`define SCP_RST_CONFIG 8'h18
`define SCP_RST_READBACK 8'h00
`define SCP_RST_PHASE_DET 8'h7D

// ************************************************************
// Register fields (configuration bits in mirrored pairs, then readback and update bits)
// ************************************************************
`define SCP_CFG_SDO_LO 0
`define SCP_CFG_LSB_LO 1
`define SCP_CFG_SOFT_LO 2
`define SCP_CFG_LONG_LO 3
`define SCP_CFG_LONG_HI 4
`define SCP_CFG_SOFT_HI 5
`define SCP_CFG_LSB_HI 6
`define SCP_CFG_SDO_HI 7
`define SCP_RB_ACTIVE 0
`define SCP_TOP_UPDATE 0

// ************************************************************
// Instruction word layout and frame counts
// ************************************************************
`define SCP_INSTR_RW 15
`define SCP_INSTR_LEN_HI 14
`define SCP_INSTR_LEN_LO 13
`define SCP_INSTR_ADDR_HI 12
`define SCP_INSTR_LAST_BIT 4'hF
`define SCP_BYTE_LAST_BIT 4'h7

`endif

/* common/scp_pkg.sv */
// Types shared by the serial control port
package scp_pkg;

  // Frame phase, one-hot
  typedef enum logic [1:0] {
    SCP_INSTR = 2'b01,
    SCP_DATA = 2'b10
  } scp_phase_type;

  // Transfer length code
  typedef enum logic [1:0] {
    SCP_LEN_ONE = 2'b00,
    SCP_LEN_TWO = 2'b01,
    SCP_LEN_THREE = 2'b10,
    SCP_LEN_STREAM = 2'b11
  } scp_len_type;

endpackage

/* logic/scp_serial_port.sv */
// Serial control port: instruction decode, address generator, register buffer
//
// Operation
// R1 - 16-bit instruction: read flag, length, address
// R2 - Length code: one, two, three bytes, stream
// R3 - Host keeps top three address bits zero
// R4 - MSB first: address decrements after each byte
// R5 - LSB first: address increments after each byte
// R6 - Host mirrors configuration byte nibbles
// R7 - Long instruction bits always stay set
// R8 - Reset selects MSB-first ordering
// R9 - LSB-first select acts at once
// R10 - Host sends MSB first, high address first
// R11 - Host sends LSB first, low address first
// R12 - LSB stream stops after address 0x232
// R13 - MSB stream wraps 0x00 to 0x232, stops
// R14 - Every address stepped, none skipped
// R15 - Sample on rising, drive on falling edge
// R16 - Update bit copies buffer to active, self-clears
// R17 - Chip select mid-byte aborts, discards data
// R18 - Readback bit picks buffer or active
// R19 - Unmapped addresses: writes ignored, reads zero
// R20 - Soft reset restores defaults, self-clears
`timescale 1ns/1ps
`include "scp_map.svh"
module scp_serial_port
  import scp_pkg::*;
(
  // System clock domain
  input wire logic clock,
  input wire logic rst,
  input wire logic clock_enable,
  // Serial link
  input wire logic sclk,
  input wire logic cs_n,
  input wire logic sdio_in,
  output logic sdio_out,
  output logic sdio_oe,
  output logic separate_serial_output,
  output logic separate_serial_output_oe,
  // System-side view
  output logic [7:0] phase_detector_control,
  output logic frame_active
);

  // ************************************************************
  // Link domain: frame tracking and bit shifting
  // ************************************************************
  logic new_frame;
  scp_phase_type phase;
  logic [3:0] bit_cnt;
  logic done;
  logic [15:0] shreg;
  logic read_op;
  scp_len_type transfer_length_code;
  logic [12:0] start_register_address;
  logic [12:0] addr;
  logic [1:0] byte_cnt;

  logic [7:0] serial_port_config;
  logic [7:0] readback_select;
  logic [7:0] pd_buffer;
  logic [7:0] phase_detector_pump_control;

  logic lsb_first;
  logic sdo_mode;
  logic stream;
  logic fresh;
  scp_phase_type cur_phase;
  logic [3:0] cur_cnt;
  logic done_eff;
  logic [15:0] next_shreg;
  logic instr_end;
  logic byte_end;
  logic [7:0] rx_byte;
  logic last_byte;
  logic [12:0] next_addr;
  logic wr_stb;
  logic cfg_wr;
  logic soft_rst;
  logic update;
  logic [7:0] rd_byte;
  logic [2:0] rd_idx;
  logic out_drive;

  // Ordering and output mode from the mirrored config byte
  assign lsb_first = serial_port_config[`SCP_CFG_LSB_LO]; // R6 R9
  assign sdo_mode = serial_port_config[`SCP_CFG_SDO_LO];

  // Marks the first rising edge after chip select was high
  always_ff @(posedge sclk or posedge cs_n) begin
    if (cs_n) begin
      new_frame <= 1'b1;
    end else begin
      new_frame <= 1'b0;
    end
  end

  // Frame restarts on mid-byte stop, completed cycle or ended stream
  assign stream = (phase == SCP_DATA) && (transfer_length_code == SCP_LEN_STREAM);
  assign fresh = new_frame && ((bit_cnt != 4'h0) || done || stream); // R17
  assign cur_phase = fresh ? SCP_INSTR : phase;
  assign cur_cnt = fresh ? 4'h0 : bit_cnt;
  assign done_eff = done && !fresh;

  // Shift direction follows bit order
  assign next_shreg = lsb_first ? {sdio_in, shreg[15:1]} : {shreg[14:0], sdio_in}; // R10 R11
  assign instr_end = !done_eff && (cur_phase == SCP_INSTR) && (cur_cnt == `SCP_INSTR_LAST_BIT);
  assign byte_end = !done_eff && (cur_phase == SCP_DATA) && (cur_cnt == `SCP_BYTE_LAST_BIT);
  assign rx_byte = lsb_first ? next_shreg[15:8] : next_shreg[7:0];

  // Last byte: count reached, or stream hit the top register
  always_comb begin
    if (transfer_length_code == SCP_LEN_STREAM) begin
      last_byte = (addr == `SCP_ADDR_TOP); // R12 R13
    end else begin
      last_byte = (byte_cnt == transfer_length_code); // R2
    end
  end

  // Address generator steps by one with no skipping; MSB first wraps from 0x000 to the top register
  always_comb begin
    if (lsb_first) begin
      next_addr = addr + 13'h0001; // R5 R14
    end else if (addr == 13'h0000) begin
      next_addr = `SCP_ADDR_TOP; // R13
    end else begin
      next_addr = addr - 13'h0001; // R4 R14
    end
  end

  // Phase, bit count and completion
  always_ff @(posedge sclk or posedge rst) begin
    if (rst) begin
      phase <= SCP_INSTR;
      bit_cnt <= 4'h0;
      done <= 1'b0;
      byte_cnt <= 2'h0;
    end else if (fresh && !instr_end) begin
      phase <= SCP_INSTR;
      bit_cnt <= 4'h1;
      done <= 1'b0;
      byte_cnt <= 2'h0;
    end else if (instr_end) begin
      phase <= SCP_DATA; // R1
      bit_cnt <= 4'h0;
      byte_cnt <= 2'h0;
    end else if (byte_end) begin
      bit_cnt <= 4'h0;
      byte_cnt <= byte_cnt + 2'h1;
      done <= last_byte; // R2 R12 R13
    end else if (!done_eff) begin
      bit_cnt <= cur_cnt + 4'h1;
    end
  end

  // Sampling on the rising edge
  always_ff @(posedge sclk or posedge rst) begin
    if (rst) begin
      shreg <= 16'h0000;
    end else if (!done_eff) begin
      shreg <= next_shreg; // R15
    end
  end

  // Instruction fields latched at the end of the word
  always_ff @(posedge sclk or posedge rst) begin
    if (rst) begin
      read_op <= 1'b0;
      transfer_length_code <= SCP_LEN_ONE;
      start_register_address <= 13'h0000;
    end else if (instr_end) begin
      read_op <= next_shreg[`SCP_INSTR_RW]; // R1
      transfer_length_code <= scp_len_type'(next_shreg[`SCP_INSTR_LEN_HI:`SCP_INSTR_LEN_LO]);
      start_register_address <= next_shreg[`SCP_INSTR_ADDR_HI:0];
    end
  end

  // Working address: start address, then one step per byte
  always_ff @(posedge sclk or posedge rst) begin
    if (rst) begin
      addr <= 13'h0000;
    end else if (instr_end) begin
      addr <= next_shreg[`SCP_INSTR_ADDR_HI:0]; // R4 R5
    end else if (byte_end && !last_byte) begin
      addr <= next_addr;
    end
  end

  // ************************************************************
  // Link domain: register file
  // ************************************************************
  assign wr_stb = byte_end && !read_op;
  assign cfg_wr = wr_stb && (addr == `SCP_ADDR_CONFIG);
  assign soft_rst = cfg_wr && (rx_byte[`SCP_CFG_SOFT_LO] || rx_byte[`SCP_CFG_SOFT_HI]);
  assign update = wr_stb && (addr == `SCP_ADDR_TOP) && rx_byte[`SCP_TOP_UPDATE];

  // Configuration acts at once; long bits forced, soft reset not stored
  always_ff @(posedge sclk or posedge rst) begin
    if (rst) begin
      serial_port_config <= `SCP_RST_CONFIG; // R8
    end else if (soft_rst) begin
      serial_port_config <= `SCP_RST_CONFIG; // R20
    end else if (cfg_wr) begin
      serial_port_config <= rx_byte | `SCP_RST_CONFIG; // R7 R9
    end
  end

  // Readback source select
  always_ff @(posedge sclk or posedge rst) begin
    if (rst) begin
      readback_select <= `SCP_RST_READBACK;
    end else if (soft_rst) begin
      readback_select <= `SCP_RST_READBACK; // R20
    end else if (wr_stb && (addr == `SCP_ADDR_READBACK)) begin
      readback_select <= {7'h00, rx_byte[`SCP_RB_ACTIVE]};
    end
  end

  // Buffered phase detector byte
  always_ff @(posedge sclk or posedge rst) begin
    if (rst) begin
      pd_buffer <= `SCP_RST_PHASE_DET;
    end else if (soft_rst) begin
      pd_buffer <= `SCP_RST_PHASE_DET; // R20
    end else if (wr_stb && (addr == `SCP_ADDR_PHASE_DET)) begin
      pd_buffer <= rx_byte;
    end
  end

  // Active copy loads on update; update bit is never stored
  always_ff @(posedge sclk or posedge rst) begin
    if (rst) begin
      phase_detector_pump_control <= `SCP_RST_PHASE_DET;
    end else if (soft_rst) begin
      phase_detector_pump_control <= `SCP_RST_PHASE_DET; // R20
    end else if (update) begin
      phase_detector_pump_control <= pd_buffer; // R16
    end
  end

  // Read mux; unmapped and update addresses return zero
  always_comb begin
    unique case (addr)
      `SCP_ADDR_CONFIG: rd_byte = serial_port_config;
      `SCP_ADDR_READBACK: rd_byte = readback_select;
      `SCP_ADDR_PHASE_DET: begin
        rd_byte = readback_select[`SCP_RB_ACTIVE] ? phase_detector_pump_control : pd_buffer; // R18
      end
      default: rd_byte = 8'h00; // R19
    endcase
  end

  // ************************************************************
  // Link domain: readback driven on the falling edge
  // ************************************************************
  assign rd_idx = lsb_first ? bit_cnt[2:0] : (3'h7 - bit_cnt[2:0]);
  assign out_drive = (phase == SCP_DATA) && read_op && !done;

  always_ff @(negedge sclk or posedge rst or posedge cs_n) begin
    if (rst) begin
      sdio_out <= 1'b0;
      sdio_oe <= 1'b0;
      separate_serial_output <= 1'b0;
      separate_serial_output_oe <= 1'b0;
    end else if (cs_n) begin
      sdio_out <= 1'b0;
      sdio_oe <= 1'b0;
      separate_serial_output <= 1'b0;
      separate_serial_output_oe <= 1'b0;
    end else begin
      sdio_out <= rd_byte[rd_idx]; // R15
      sdio_oe <= out_drive && !sdo_mode;
      separate_serial_output <= rd_byte[rd_idx];
      separate_serial_output_oe <= out_drive && sdo_mode;
    end
  end

  // ************************************************************
  // Crossing of the active byte to the system domain
  // ************************************************************
  logic xfer_req;
  logic xfer_pend;
  logic [7:0] xfer_data;
  logic xfer_ack;
  logic ack_sync;
  logic req_sync;
  logic cs_sync;
  logic xfer_busy;

  scp_sync3 #(.WIDTH(1)) ack_sync_inst (
    .clk(sclk),
    .rst(rst),
    .ce(1'b1),
    .async_in(xfer_ack),
    .sync_out(ack_sync)
  );

  assign xfer_busy = (xfer_req != ack_sync);

  // Snapshot held stable while a request is outstanding
  always_ff @(posedge sclk or posedge rst) begin
    if (rst) begin
      xfer_req <= 1'b0;
      xfer_pend <= 1'b0;
      xfer_data <= `SCP_RST_PHASE_DET;
    end else if (!xfer_busy && (update || soft_rst || xfer_pend)) begin
      xfer_req <= ~xfer_req;
      xfer_pend <= 1'b0;
      if (soft_rst) begin
        xfer_data <= `SCP_RST_PHASE_DET;
      end else if (update) begin
        xfer_data <= pd_buffer;
      end else begin
        xfer_data <= phase_detector_pump_control;
      end
    end else if (update || soft_rst) begin
      xfer_pend <= 1'b1;
    end
  end

  // ************************************************************
  // System domain
  // ************************************************************
  scp_sync3 #(.WIDTH(1)) req_sync_inst (
    .clk(clock),
    .rst(rst),
    .ce(clock_enable),
    .async_in(xfer_req),
    .sync_out(req_sync)
  );

  scp_sync3 #(.WIDTH(1)) cs_sync_inst (
    .clk(clock),
    .rst(rst),
    .ce(clock_enable),
    .async_in(~cs_n),
    .sync_out(cs_sync)
  );

  // Capture the snapshot and acknowledge
  always_ff @(posedge clock) begin
    if (rst) begin
      xfer_ack <= 1'b0;
      phase_detector_control <= `SCP_RST_PHASE_DET;
    end else if (clock_enable && (req_sync != xfer_ack)) begin
      xfer_ack <= req_sync;
      phase_detector_control <= xfer_data;
    end
  end

  // Frame indicator; select synchronised active high, so reset equals idle
  always_ff @(posedge clock) begin
    if (rst) begin
      frame_active <= 1'b0;
    end else if (clock_enable) begin
      frame_active <= cs_sync;
    end
  end

endmodule

/* logic/scp_sync3.sv */
// Three-stage synchroniser; output follows once stages two and three agree
`timescale 1ns/1ps
module scp_sync3 #(
  parameter int WIDTH = 1
) (
  // Clock and control
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  // Data
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] stage1;
  logic [WIDTH-1:0] stage2;
  logic [WIDTH-1:0] stage3;

  // Shift chain; stage1 feeds only stage2
  always_ff @(posedge clk) begin
    if (rst) begin
      stage1 <= '0;
      stage2 <= '0;
      stage3 <= '0;
    end else if (ce) begin
      stage1 <= async_in;
      stage2 <= stage1;
      stage3 <= stage2;
    end
  end

  // Accept a change once two stages agree
  always_ff @(posedge clk) begin
    if (rst) begin
      sync_out <= '0;
    end else if (ce && (stage2 == stage3)) begin
      sync_out <= stage3;
    end
  end

endmodule

/* tb/scp_host.sv */
// Host model: bus master of the serial link
`timescale 1ns/1ps
module scp_host (
  // Serial link
  output logic sclk,
  output logic cs_n,
  output logic sdio_in,
  input wire logic sdio_out,
  input wire logic sdio_oe,
  input wire logic separate_serial_output,
  input wire logic separate_serial_output_oe
);
  logic drv;
  logic lsb;
  logic oe0;
  logic last_oe;
  logic [7:0] rx_byte;
  event got;

  // Wire level: device wins while it drives
  assign sdio_in = sdio_oe ? sdio_out : drv;

  // Idle link, clock parked low
  initial begin
    sclk = 1'b0;
    cs_n = 1'b1;
    drv = 1'b0;
    lsb = 1'b0;
    oe0 = 1'b0;
    last_oe = 1'b0;
    rx_byte = 8'h00;
  end

  // Up to eight bits; a released line toggles every bit
  task automatic shift(input logic [7:0] b, input int cnt, input bit rd);
    int k;
    for (int i = 0; i < cnt; i++) begin
      k = lsb ? i : 7 - i;
      drv = rd ? ~drv : b[k];
      #3 sclk = 1'b1;
      last_oe = sdio_oe | separate_serial_output_oe;
      rx_byte[k] = sdio_oe ? sdio_out : separate_serial_output;
      if (i == 0) oe0 = last_oe;
      #3 sclk = 1'b0;
    end
  endtask

  // One frame: instruction, n bytes, then part bits of a torn byte
  task automatic go(input logic [15:0] ins, input int n, input logic [23:0] d,
    input int part);
    #1.7 cs_n = 1'b0;
    #2;
    shift(lsb ? ins[7:0] : ins[15:8], 8, 1'b0);
    shift(lsb ? ins[15:8] : ins[7:0], 8, 1'b0);
    repeat (n) begin
      shift(d[23:16], 8, ins[15]);
      d = d << 8;
      if (ins[15] && oe0) ->got;
    end
    shift(8'hFF, part, 1'b0);
    #2 cs_n = 1'b1;
    #10;
  endtask

  // Remaining byte of a transfer stalled on a byte boundary
  task automatic resume(input logic [7:0] b);
    #1.7 cs_n = 1'b0;
    #2;
    shift(b, 8, 1'b0);
    #2 cs_n = 1'b1;
    #10;
  endtask
endmodule

/* tb/scp_serial_port_sva.sv */
// Checker for the serial control port pins
`timescale 1ns/1ps
module scp_chk (
  // System side
  input wire logic clock,
  input wire logic rst,
  input wire logic clock_enable,
  input wire logic [7:0] phase_detector_control,
  input wire logic frame_active,
  // Serial link
  input wire logic sclk,
  input wire logic cs_n,
  input wire logic sdio_oe,
  input wire logic separate_serial_output_oe
);
  logic [9:0] n_edge;
  logic [2:0] n_idle;
  wire logic any_oe;

  // Either readback pin driven
  assign any_oe = sdio_oe | separate_serial_output_oe;

  // Rising sclk edges seen in this frame
  always_ff @(posedge sclk or posedge cs_n) begin
    if (cs_n) begin
      n_edge <= 10'h000;
    end else if (n_edge != 10'h3FF) begin
      n_edge <= n_edge + 10'h001;
    end
  end

  a_oe_cs_idle: assert property (@(posedge clock) disable iff (rst)
    cs_n |-> !any_oe) else $error("readback driven while deselected");
  // Enabled system clocks seen with the chip deselected
  always_ff @(posedge clock) begin
    if (rst || !cs_n) begin
      n_idle <= 3'h0;
    end else if (clock_enable && (n_idle != 3'h7)) begin
      n_idle <= n_idle + 3'h1;
    end
  end

  a_frame_idle: assert property (@(posedge clock) disable iff (rst)
    n_idle >= 3'h5 |-> !frame_active) else $error("frame flag stuck high");
  a_rst_values: assert property (@(posedge clock) disable iff (rst)
    $fell(rst) |-> phase_detector_control == 8'h7D && !frame_active && !any_oe)
    else $error("wrong state after reset");
  a_pdc_freeze: assert property (@(posedge clock) disable iff (rst)
    !clock_enable |=> $stable(phase_detector_control))
    else $error("active byte moved while frozen");
  a_no_early_oe: assert property (@(negedge sclk) disable iff (rst)
    n_edge <= 10'h010 |-> !any_oe) else $error("readback inside instruction");
  a_oe_rise_count: assert property (@(negedge sclk) disable iff (rst)
    $rose(any_oe) |-> n_edge == 10'h011) else $error("readback started late");
  a_oe_fall_byte: assert property (@(negedge sclk) disable iff (rst)
    $fell(any_oe) && n_edge > 10'h001 |-> n_edge[2:0] == 3'h1 && n_edge >= 10'h019)
    else $error("readback ended off a byte boundary");
  a_oe_one_pin: assert property (@(negedge sclk) disable iff (rst)
    !(sdio_oe && separate_serial_output_oe)) else $error("both readback pins driven");
endmodule

bind scp_serial_port scp_chk chk (.clock(clock), .rst(rst), .clock_enable(clock_enable),
  .phase_detector_control(phase_detector_control), .frame_active(frame_active),
  .sclk(sclk), .cs_n(cs_n), .sdio_oe(sdio_oe),
  .separate_serial_output_oe(separate_serial_output_oe));

/* tb/serial_control_port_framing_tb.sv */
// Self-checking bench for the serial control port
`timescale 1ns/1ps
module serial_control_port_framing_tb;
  logic clock, rst, sclk, cs_n, sdio_in;
  logic clock_enable = 1'b1;
  logic sdio_out, sdio_oe, sso, sso_oe, frame_active;
  logic [7:0] pdc;
  logic [7:0] dat;
  logic [16:0] seed = 17'h1_46EF;
  int n_mismatch = 0;
  int samples_checked = 0;
  int n_cyc = 0;
  logic [7:0] q[$];

  scp_serial_port dut (.clock(clock), .rst(rst), .clock_enable(clock_enable), .sclk(sclk),
    .cs_n(cs_n), .sdio_in(sdio_in), .sdio_out(sdio_out), .sdio_oe(sdio_oe),
    .separate_serial_output(sso), .separate_serial_output_oe(sso_oe),
    .phase_detector_control(pdc), .frame_active(frame_active));
  scp_host host (.sclk(sclk), .cs_n(cs_n), .sdio_in(sdio_in), .sdio_out(sdio_out),
    .sdio_oe(sdio_oe), .separate_serial_output(sso), .separate_serial_output_oe(sso_oe));

  // *****
  // Helpers
  // *****
  function automatic logic [16:0] lfsr(input logic [16:0] s);
    return {s[15:0], s[16] ^ s[13]};
  endfunction

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("ERROR %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic stop_test;
    $display("checked %0d mismatches %0d", samples_checked, n_mismatch);
    if (n_mismatch == 0 && samples_checked > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  // Note up to three expected bytes, then read
  task automatic rd(input logic [15:0] ins, input int n, input logic [23:0] e);
    for (int i = 0; i < n && i < 3; i++) q.push_back(e[23-8*i -: 8]);
    host.go(ins, n, 24'h00_0000, 0);
  endtask

  task automatic wait_pdc(input logic [7:0] e);
    for (int i = 0; i < 60 && pdc !== e; i++) @(negedge clock);
    check(pdc, e);
  endtask

  // Clock
  initial begin
    clock = 1'b0;
    forever #50 clock = ~clock;
  end

  // Random clock enable, hang guard
  always @(negedge clock) begin
    seed <= lfsr(seed);
    clock_enable <= rst | (seed[1:0] != 2'h0);
    n_cyc <= n_cyc + 1;
    if (n_cyc == 3000) begin
      n_mismatch++;
      stop_test;
    end
  end

  // Oldest expected readback against each received byte
  always @(host.got) check(host.rx_byte, q.pop_front());

  // *****
  // Scenarios
  // *****
  initial begin
    rst = 1'b1;
    repeat (8) @(negedge clock);
    rst = 1'b0;
    @(negedge clock);
    check(pdc, 8'h7D);
    // Reset order, length codes, downward stepping
    rd(16'h8000, 1, 24'h18_0000);
    rd(16'hC010, 3, 24'h7D_0000);
    // Buffered write, readback select, update
    dat = seed[7:0];
    host.go(16'h0010, 1, {dat, 16'h0000}, 0);
    rd(16'h8010, 1, {dat, 16'h0000});
    host.go(16'h0004, 1, 24'h01_0000, 0);
    rd(16'h8010, 1, 24'h7D_0000);
    check(pdc, 8'h7D);
    host.go(16'h0232, 1, 24'h01_0000, 0);
    wait_pdc(dat);
    rd(16'h8010, 1, {dat, 16'h0000});
    rd(16'h8232, 1, 24'h00_0000);
    // Torn byte, then unmapped write
    host.go(16'h0010, 0, 24'h00_0000, 5);
    host.go(16'h0004, 1, 24'h00_0000, 0);
    rd(16'h8010, 1, {dat, 16'h0000});
    host.go(16'h0020, 1, 24'hFF_0000, 0);
    rd(16'h8020, 1, 24'h00_0000);
    // Stall on a byte boundary, then resume with the second byte
    host.go(16'h2011, 1, 24'hA5_0000, 0);
    host.resume(~dat);
    rd(16'h8010, 1, {~dat, 16'h0000});
    host.go(16'h0010, 1, {dat, 16'h0000}, 0);
    // Downward stream wraps to the top and stops
    host.go(16'h6001, 4, 24'h00_1800, 0);
    rd(16'hE001, 4, 24'h00_1800);
    check({7'h00, host.last_oe}, 8'h00);
    // Separate output pin
    host.go(16'h0000, 1, 24'h99_0000, 0);
    rd(16'h8010, 1, {dat, 16'h0000});
    host.go(16'h0000, 1, 24'h00_0000, 0);
    rd(16'h8000, 1, 24'h18_0000);
    // LSB first at once, upward stepping and stream
    host.go(16'h0000, 1, 24'h5A_0000, 0);
    host.lsb = 1'b1;
    rd(16'h8000, 1, 24'h5A_0000);
    host.go(16'h200F, 2, 24'h11_3C00, 0);
    rd(16'h8010, 1, 24'h3C_0000);
    host.go(16'h6230, 3, 24'h00_0001, 0);
    wait_pdc(8'h3C);
    rd(16'hE230, 4, 24'h00_0000);
    check({7'h00, host.last_oe}, 8'h00);
    // Soft reset restores defaults and MSB order
    host.go(16'h0000, 1, 24'h3C_0000, 0);
    host.lsb = 1'b0;
    rd(16'h8000, 1, 24'h18_0000);
    rd(16'h8010, 1, 24'h7D_0000);
    wait_pdc(8'h7D);
    repeat (12) @(negedge clock);
    check(8'(q.size()), 8'h00);
    stop_test;
  end
endmodule
